// ### src/twroc_pkg.sv
// constants and carrier types of the tag word read output control block
package twroc_pkg;
	// clock rate and documented off-delay / blink times
	localparam int unsigned CLK_KHZ      = 200000;
	localparam int unsigned OFF_DLY0_MS  = 10;
	localparam int unsigned OFF_DLY1_MS  = 50;
	localparam int unsigned OFF_DLY2_MS  = 500;
	localparam int unsigned BLINK_MS     = 250;
	localparam int unsigned CNT_W        = 27;
	localparam int unsigned INIT_CYC     = 3;
	// leading address limits per carrier kind
	localparam logic [7:0]  ADDR_LIM_RAM = 8'hFF;
	localparam logic [7:0]  ADDR_LIM_ROM = 8'hFC;
	// error code bit positions
	localparam int unsigned ERR_XMIT     = 0;
	localparam int unsigned ERR_NOCAR    = 2;
	localparam int unsigned ERR_ADDR     = 3;
	localparam int unsigned ERR_WORD     = 5;
	localparam int unsigned ERR_HW       = 7;
	// wiring-saving reserved words
	localparam logic [15:0] WORD_CTRL    = 16'h0000;
	localparam logic [15:0] WORD_ERR     = 16'hFFFF;
	// register indices and reset values
	localparam logic [3:0]  REG_STATUS   = 4'h0;
	localparam logic [3:0]  REG_WORD     = 4'h1;
	localparam logic [3:0]  REG_ERRCODE  = 4'h2;
	localparam logic [3:0]  REG_CFG      = 4'h3;
	localparam logic        CFG_ROM_RST  = 1'b0;
	localparam int unsigned CFG_ROM_BIT  = 0;

	// byte fetch request towards the carrier front end
	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
	} twroc_req_s;

	// byte fetch answer from the carrier front end
	typedef struct packed {
		logic       done;
		logic       fail;
		logic [7:0] data;
	} twroc_rsp_s;

	typedef enum logic [2:0] {
		ST_INIT,
		ST_IDLE,
		ST_BYTE0,
		ST_BYTE1
	} twroc_state_e;
endpackage : twroc_pkg

// ### src/twroc_top.sv
// tag word read output control: carrier fetch, hold, off-delay and indicators
// Operation
// R1: mode switches captured once after power-up
// R2: fetch two bytes, leading then next address
// R3: left switch upper digit, right lower
// R4: leading address 00-FF, eeprom limit FC
// R5: auto mode reads arriving carrier unprompted
// R6: auto rearms on departure or suppress release
// R7: requested mode idles until read request
// R8: request without carrier flags missing-carrier error
// R9: off-delay governs data, done, strobe, error, parity
// R10: hold while carrier present, then timer
// R11: three selectable delays, clear on expiry
// R12: suppress or new request clears at once
// R13: standard mode: data, done, error lines
// R14: standard mode error code on data lines
// R15: error code lines cleared after off-delay
// R16: wiring-saving mode uses data lines plus strobe
// R17: host wires thirteen lines plus strobe
// R18: green indicators hold last read word
// R19: red indicators flash code until next read
// R20: parity high when odd lines set
// R21: wiring-saving reserves 0000 and FFFF words
// R22: one error bit per fault kind
// R23: good-completion line follows data timing
// R24: leading byte forms upper half
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// three-stage input synchroniser, change taken when stages two and three agree
module twroc_sync3 #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] s1_q, s2_q, s3_q;

	// shift chain plus agreement filter
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			q_o  <= '0;
		end else begin
			s1_q <= d_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q_o  <= (s2_q & s3_q) | (q_o & (s2_q ^ s3_q));
		end
	end
endmodule : twroc_sync3

module twroc_top #(
	parameter int unsigned DLY0_CYC  = twroc_pkg::OFF_DLY0_MS * twroc_pkg::CLK_KHZ,
	parameter int unsigned DLY1_CYC  = twroc_pkg::OFF_DLY1_MS * twroc_pkg::CLK_KHZ,
	parameter int unsigned DLY2_CYC  = twroc_pkg::OFF_DLY2_MS * twroc_pkg::CLK_KHZ,
	parameter int unsigned BLINK_CYC = twroc_pkg::BLINK_MS * twroc_pkg::CLK_KHZ
) (
	input  wire logic                   clk_i,
	input  wire logic                   nrst_i,
	input  wire logic [3:0]             addr_sw_hi_i,
	input  wire logic [3:0]             addr_sw_lo_i,
	input  wire logic                   access_auto_sw_i,
	input  wire logic [1:0]             off_delay_sw_i,
	input  wire logic                   out_mode2_sw_i,
	input  wire logic                   carrier_present_i,
	input  wire logic                   suppress_i,
	input  wire logic                   read_request_in_i,
	output twroc_pkg::twroc_req_s       car_req_o,
	input  wire twroc_pkg::twroc_rsp_s  car_rsp_i,
	output logic [15:0]                 carrier_word_lines_o,
	output logic                        good_done_o,
	output logic                        error_o,
	output logic                        read_done_pulse_o,
	output logic                        parity_o,
	output logic [15:0]                 green_led_o,
	output logic [7:0]                  red_led_o,
	input  wire logic [3:0]             reg_addr_i,
	input  wire logic [15:0]            reg_wdata_i,
	input  wire logic                   reg_we_i,
	input  wire logic                   reg_re_i,
	output logic [15:0]                 reg_rdata_o
);
	localparam int unsigned CW = twroc_pkg::CNT_W;

	logic [11:0]             sw_q;
	logic                    carr, sup, req_in;
	logic                    sup_p_q, req_p_q;
	logic                    sup_rise, sup_fall, req_rise, clear_now;
	twroc_pkg::twroc_state_e st_q;
	logic [2:0]              init_q;
	logic                    auto_q, mode2_q, sw_bad_q;
	logic [1:0]              dly_sel_q;
	logic                    armed_q;
	logic [7:0]              lead_q, hi_q, lim;
	logic                    res_v_q;
	logic [15:0]             res_word_q;
	logic [7:0]              res_code_q, red_code_q;
	logic                    act_q;
	logic [CW-1:0]           cnt_q, dly_load;
	logic [CW-1:0]           blink_cnt_q;
	logic                    blink_q;
	logic                    cfg_rom_q;
	logic                    start;

	// pins into the clock domain
	twroc_sync3 #(.W(15)) u_sync (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.d_i    ({addr_sw_hi_i, addr_sw_lo_i, access_auto_sw_i, off_delay_sw_i,
			out_mode2_sw_i, carrier_present_i, suppress_i, read_request_in_i}),
		.q_o    ({sw_q[7:0], sw_q[10], sw_q[9:8], sw_q[11], carr, sup, req_in})
	);

	// edge history of suppress and request
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			sup_p_q <= 1'b0;
			req_p_q <= 1'b0;
		end else begin
			sup_p_q <= sup;
			req_p_q <= req_in;
		end
	end

	assign sup_rise  = sup & ~sup_p_q;
	assign sup_fall  = ~sup & sup_p_q;
	assign req_rise  = req_in & ~req_p_q;
	assign clear_now = (st_q != twroc_pkg::ST_INIT)
		& ((auto_q & sup_rise) | (~auto_q & req_rise)); // [R12]
	assign lim       = cfg_rom_q ? twroc_pkg::ADDR_LIM_ROM : twroc_pkg::ADDR_LIM_RAM; // [R4]
	assign start     = (st_q == twroc_pkg::ST_IDLE) & ~sw_bad_q
		& ((auto_q & armed_q & carr & ~sup) | (~auto_q & req_rise & carr)); // [R5] [R7]

	// fetch request is a level while a byte is outstanding
	always_comb begin
		car_req_o.valid = (st_q == twroc_pkg::ST_BYTE0) | (st_q == twroc_pkg::ST_BYTE1);
		car_req_o.addr  = (st_q == twroc_pkg::ST_BYTE1) ? 16'(lead_q) + 16'h0001
			: 16'(lead_q); // [R2]
	end

	// read sequencer, power-up capture and result
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			st_q       <= twroc_pkg::ST_INIT;
			init_q     <= 3'h0;
			auto_q     <= 1'b0;
			mode2_q    <= 1'b0;
			dly_sel_q  <= 2'h0;
			sw_bad_q   <= 1'b0;
			lead_q     <= 8'h00;
			hi_q       <= 8'h00;
			res_v_q    <= 1'b0;
			res_word_q <= 16'h0000;
			res_code_q <= 8'h00;
			red_code_q <= 8'h00;
		end else begin
			res_v_q <= 1'b0;
			case (st_q)
				twroc_pkg::ST_INIT: begin
					init_q <= init_q + 3'h1;
					if (init_q == 3'(twroc_pkg::INIT_CYC) + 3'h1) begin
						// switches settle through the synchroniser first
						auto_q    <= sw_q[10]; // [R1]
						dly_sel_q <= sw_q[9:8];
						mode2_q   <= sw_q[11];
						sw_bad_q  <= (sw_q[9:8] == 2'h3);
						st_q      <= twroc_pkg::ST_IDLE;
						if (sw_q[9:8] == 2'h3) begin
							res_v_q    <= 1'b1;
							res_code_q <= 8'h01 << twroc_pkg::ERR_HW; // [R22]
							red_code_q <= 8'h01 << twroc_pkg::ERR_HW;
						end
					end
				end
				twroc_pkg::ST_IDLE: begin
					if (start) begin
						lead_q     <= sw_q[7:0]; // [R3]
						red_code_q <= 8'h00; // [R19]
						if (sw_q[7:0] > lim) begin
							res_v_q    <= 1'b1;
							res_code_q <= 8'h01 << twroc_pkg::ERR_ADDR; // [R4]
							red_code_q <= 8'h01 << twroc_pkg::ERR_ADDR;
						end else begin
							st_q <= twroc_pkg::ST_BYTE0;
						end
					end else if (~auto_q & req_rise & ~carr & ~sw_bad_q) begin
						res_v_q    <= 1'b1;
						res_code_q <= 8'h01 << twroc_pkg::ERR_NOCAR; // [R8]
						red_code_q <= 8'h01 << twroc_pkg::ERR_NOCAR;
					end
				end
				twroc_pkg::ST_BYTE0: begin
					if (car_rsp_i.done) begin
						hi_q <= car_rsp_i.data; // [R24]
						st_q <= car_rsp_i.fail ? twroc_pkg::ST_IDLE : twroc_pkg::ST_BYTE1;
						if (car_rsp_i.fail) begin
							res_v_q    <= 1'b1;
							res_code_q <= 8'h01 << twroc_pkg::ERR_XMIT;
							red_code_q <= 8'h01 << twroc_pkg::ERR_XMIT;
						end
					end
				end
				twroc_pkg::ST_BYTE1: begin
					if (car_rsp_i.done) begin
						st_q       <= twroc_pkg::ST_IDLE;
						res_v_q    <= 1'b1;
						res_word_q <= {hi_q, car_rsp_i.data}; // [R24]
						res_code_q <= 8'h00;
						if (car_rsp_i.fail) begin
							res_code_q <= 8'h01 << twroc_pkg::ERR_XMIT;
							red_code_q <= 8'h01 << twroc_pkg::ERR_XMIT;
						end else if (mode2_q & (({hi_q, car_rsp_i.data} == twroc_pkg::WORD_CTRL)
							| ({hi_q, car_rsp_i.data} == twroc_pkg::WORD_ERR))) begin
							res_code_q <= 8'h01 << twroc_pkg::ERR_WORD; // [R21]
							red_code_q <= 8'h01 << twroc_pkg::ERR_WORD;
						end
					end
				end
				default: begin
					st_q <= twroc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// auto-mode rearm after departure or suppress release
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			armed_q <= 1'b1;
		end else if (start) begin
			armed_q <= 1'b0; // [R6]
		end else if (~carr | sup_fall) begin
			armed_q <= 1'b1; // [R6]
		end
	end

	// off-delay reload value from captured switch
	always_comb begin
		case (dly_sel_q)
			2'h0:    dly_load = CW'(DLY0_CYC - 1);
			2'h1:    dly_load = CW'(DLY1_CYC - 1);
			default: dly_load = CW'(DLY2_CYC - 1);
		endcase
	end

	// governed outputs: present, hold, off-delay, forced clear
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			act_q                <= 1'b0;
			cnt_q                <= '0;
			carrier_word_lines_o <= 16'h0000;
			good_done_o          <= 1'b0;
			error_o              <= 1'b0;
			read_done_pulse_o    <= 1'b0;
			parity_o             <= 1'b0;
			green_led_o          <= 16'h0000;
		end else if (clear_now) begin
			act_q                <= 1'b0; // [R12]
			carrier_word_lines_o <= 16'h0000;
			good_done_o          <= 1'b0;
			error_o              <= 1'b0;
			read_done_pulse_o    <= 1'b0;
			parity_o             <= 1'b0;
		end else if (res_v_q) begin
			act_q             <= 1'b1;
			cnt_q             <= dly_load;
			error_o           <= (res_code_q != 8'h00); // [R8]
			good_done_o       <= ~mode2_q & (res_code_q == 8'h00); // [R13] [R23]
			read_done_pulse_o <= mode2_q; // [R16]
			if (res_code_q == 8'h00) begin
				carrier_word_lines_o <= res_word_q;
				parity_o             <= ^res_word_q; // [R20]
				green_led_o          <= res_word_q; // [R18]
			end else if (mode2_q) begin
				carrier_word_lines_o <= twroc_pkg::WORD_ERR; // [R21]
				parity_o             <= ^twroc_pkg::WORD_ERR;
			end else begin
				carrier_word_lines_o <= {8'h00, res_code_q}; // [R14]
				parity_o             <= ^res_code_q;
			end
		end else if (act_q) begin
			if (carr) begin
				cnt_q <= dly_load; // [R10]
			end else if (cnt_q != '0) begin
				cnt_q <= cnt_q - CW'(1); // [R11]
			end else begin
				act_q                <= 1'b0; // [R9] [R15]
				carrier_word_lines_o <= 16'h0000;
				good_done_o          <= 1'b0;
				error_o              <= 1'b0;
				read_done_pulse_o    <= 1'b0;
				parity_o             <= 1'b0;
			end
		end
	end

	// red indicator blink divider
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			blink_cnt_q <= '0;
			blink_q     <= 1'b0;
		end else if (blink_cnt_q == CW'(BLINK_CYC - 1)) begin
			blink_cnt_q <= '0;
			blink_q     <= ~blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + CW'(1);
		end
	end

	assign red_led_o = blink_q ? red_code_q : 8'h00; // [R19]

	// register port: cfg write, status reads
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			cfg_rom_q   <= twroc_pkg::CFG_ROM_RST;
			reg_rdata_o <= 16'h0000;
		end else begin
			if (reg_we_i && reg_addr_i == twroc_pkg::REG_CFG) begin
				cfg_rom_q <= reg_wdata_i[twroc_pkg::CFG_ROM_BIT];
			end
			reg_rdata_o <= 16'h0000;
			if (reg_re_i) begin
				case (reg_addr_i)
					twroc_pkg::REG_STATUS:  reg_rdata_o <= {5'h00, sw_bad_q, dly_sel_q,
						mode2_q, auto_q, armed_q, carr, act_q, 3'(st_q)};
					twroc_pkg::REG_WORD:    reg_rdata_o <= res_word_q;
					twroc_pkg::REG_ERRCODE: reg_rdata_o <= {8'h00, red_code_q};
					twroc_pkg::REG_CFG:     reg_rdata_o <= {15'h0000, cfg_rom_q};
					default:                reg_rdata_o <= 16'h0000;
				endcase
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	cfg_frozen_a: assert property ((st_q != twroc_pkg::ST_INIT) |=> // [R1]
		$stable(auto_q) && $stable(dly_sel_q) && $stable(mode2_q))
		else $error("mode switches changed after capture");
	second_byte_a: assert property ((st_q == twroc_pkg::ST_BYTE0) // [R2]
		&& car_rsp_i.done && !car_rsp_i.fail |=> car_req_o.valid
		&& car_req_o.addr == $past(car_req_o.addr) + 16'h0001)
		else $error("second byte not at next address");
	force_clear_a: assert property (clear_now |=> // [R12]
		carrier_word_lines_o == 16'h0000
		&& !error_o && !good_done_o && !read_done_pulse_o)
		else $error("outputs not cleared at once");
	parity_match_a: assert property (parity_o == ^carrier_word_lines_o) // [R20]
		else $error("parity does not match data lines");
	hold_carrier_a: assert property (act_q && carr && !clear_now && !res_v_q |=> // [R10]
		act_q && $stable(carrier_word_lines_o))
		else $error("outputs dropped with carrier present");
	std_good_a: assert property (res_v_q && !clear_now && !mode2_q // [R23]
		&& res_code_q == 8'h00
		|=> good_done_o && carrier_word_lines_o == $past(res_word_q))
		else $error("good completion missing with data");
	std_errcode_a: assert property (res_v_q && !clear_now && !mode2_q // [R14]
		&& res_code_q != 8'h00
		|=> error_o && carrier_word_lines_o[7:0] == $past(res_code_q))
		else $error("error code not on data lines");
	reserved_word_a: assert property (read_done_pulse_o && !error_o |-> // [R21]
		carrier_word_lines_o != twroc_pkg::WORD_CTRL
		&& carrier_word_lines_o != twroc_pkg::WORD_ERR)
		else $error("reserved word shown as data");
	green_keep_a: assert property ($fell(act_q) |-> $stable(green_led_o)) // [R18]
		else $error("green indicators changed at clear");
	sync_wait_a: assert property (!auto_q && st_q == twroc_pkg::ST_IDLE // [R7]
		&& !req_rise |=> st_q != twroc_pkg::ST_BYTE0)
		else $error("read without request");

	auto_read_c: cover property (auto_q && start ##[1:20] res_v_q);
	nocar_err_c: cover property (res_v_q && res_code_q[twroc_pkg::ERR_NOCAR]);
	off_delay_c: cover property (act_q && !carr ##1 $fell(act_q));
endmodule : twroc_top
`default_nettype wire

// ### verif/twroc_car_model.sv
// behavioural carrier front end answering byte fetches
`timescale 1ns/100ps
`default_nettype none

module twroc_car_model (
	input  wire logic                  clk_i,
	input  wire logic                  nrst_i,
	input  wire twroc_pkg::twroc_req_s req_i,
	output var twroc_pkg::twroc_rsp_s  rsp_o,
	input  wire logic [3:0]            lat_i,
	input  wire logic                  fail_i,
	input  wire logic                  ones_i,
	output logic [7:0]                 nfetch_o,
	output logic [15:0]                addr_prev_o,
	output logic [15:0]                addr_last_o
);
	logic [3:0] cnt_q;

	// answer after lat_i waiting cycles; data toggles while no fetch is pending and just after an answer, held while waiting
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			cnt_q       <= 4'h0;
			rsp_o       <= '0;
			nfetch_o    <= 8'h00;
			addr_prev_o <= 16'h0000;
			addr_last_o <= 16'h0000;
		end else if (rsp_o.done) begin
			rsp_o.done <= 1'b0;
			rsp_o.fail <= 1'b0;
			rsp_o.data <= ~rsp_o.data; // released bus, no stale value
			cnt_q      <= 4'h0;
		end else if (req_i.valid) begin
			if (cnt_q == lat_i) begin
				rsp_o.done  <= 1'b1;
				rsp_o.fail  <= fail_i;
				rsp_o.data  <= ones_i ? 8'hFF : (req_i.addr[7:0] ^ 8'h5A);
				nfetch_o    <= nfetch_o + 8'h01;
				addr_prev_o <= addr_last_o;
				addr_last_o <= req_i.addr;
			end else begin
				cnt_q <= cnt_q + 4'h1;
			end
		end else begin
			cnt_q      <= 4'h0;
			rsp_o.data <= ~rsp_o.data;
		end
	end
endmodule : twroc_car_model

`default_nettype wire

// ### verif/tag_word_read_output_control_bench.sv
// self-checking bench of the tag word read output control block
`timescale 1ns/100ps
`default_nettype none

module tag_word_read_output_control_bench;
	logic                  clk_i = 1'b0;
	logic                  nrst_i = 1'b0;
	logic [3:0]            hi = 4'h0, lo = 4'h0, ra = 4'h0, lat = 4'h2;
	logic                  aut = 1'b0, m2 = 1'b0, sup = 1'b0, car = 1'b0, req = 1'b0;
	logic                  fail = 1'b0, ones = 1'b0, we = 1'b0, re = 1'b0;
	logic [1:0]            dly = 2'h0;
	logic [15:0]           rwd = 16'h0000;
	twroc_pkg::twroc_req_s creq;
	twroc_pkg::twroc_rsp_s crsp;
	logic [15:0]           lines, green, rdata, ap, al;
	logic                  gd, er, stb, par;
	logic [7:0]            red, nf;
	int                    num_errors = 0, n_tests = 0, cyc = 0;

	always #2.5 clk_i = ~clk_i;

	twroc_top #(.DLY0_CYC(20), .DLY1_CYC(40), .DLY2_CYC(80), .BLINK_CYC(8)) dut_u (
		.clk_i(clk_i), .nrst_i(nrst_i), .addr_sw_hi_i(hi), .addr_sw_lo_i(lo),
		.access_auto_sw_i(aut), .off_delay_sw_i(dly), .out_mode2_sw_i(m2),
		.carrier_present_i(car), .suppress_i(sup), .read_request_in_i(req),
		.car_req_o(creq), .car_rsp_i(crsp), .carrier_word_lines_o(lines),
		.good_done_o(gd), .error_o(er), .read_done_pulse_o(stb), .parity_o(par),
		.green_led_o(green), .red_led_o(red), .reg_addr_i(ra), .reg_wdata_i(rwd),
		.reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata));

	twroc_car_model car_u (
		.clk_i(clk_i), .nrst_i(nrst_i), .req_i(creq), .rsp_o(crsp), .lat_i(lat),
		.fail_i(fail), .ones_i(ones), .nfetch_o(nf), .addr_prev_o(ap), .addr_last_o(al));

	task automatic complete_run();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run

	// hang guard
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			complete_run();
		end
	end

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick

	// switches set before reset release, then init and sync settle
	task automatic rst(input logic a, input logic [1:0] d, input logic m,
			input logic [3:0] h, input logic [3:0] l);
		tick(1);
		aut <= a; dly <= d; m2 <= m; hi <= h; lo <= l; nrst_i <= 1'b0;
		tick(3);
		nrst_i <= 1'b1;
		tick(12);
	endtask : rst

	// wait for any result line, bounded
	task automatic wres();
		int i;
		i = 0;
		tick(1);
		while ((gd | er | stb) !== 1'b1 && i < 200) begin
			tick(1);
			i++;
		end
		chk(16'(i < 200), 16'h0001);
		tick(1);
	endtask : wres

	task automatic rq();
		req <= 1'b1;
		tick(4);
		req <= 1'b0;
	endtask : rq

	task automatic rw(input logic [3:0] a, input logic [15:0] d);
		ra <= a; rwd <= d; we <= 1'b1;
		tick(1);
		we <= 1'b0;
		tick(1);
	endtask : rw

	task automatic rr(input logic [3:0] a, input logic [15:0] e);
		ra <= a; re <= 1'b1;
		tick(1);
		re <= 1'b0;
		tick(1);
		chk(rdata, e);
	endtask : rr

	// gather the flashing red pattern over three blink half-periods
	task automatic redacc(input logic [7:0] e);
		logic [7:0] acc;
		acc = 8'h00;
		repeat (24) begin
			tick(1);
			acc = acc | red;
		end
		chk({8'h00, acc}, {8'h00, e});
	endtask : redacc

	function automatic logic [15:0] wexp(input logic [7:0] a);
		return {a ^ 8'h5A, (a + 8'h01) ^ 8'h5A};
	endfunction : wexp

	// main sequence
	initial begin
		rst(1'b0, 2'h0, 1'b0, 4'h5, 4'h3);
		chk(lines, 16'h0000);
		rq();
		wres();
		chk(lines, 16'h0004);
		chk(16'(er), 16'h0001);
		redacc(8'h04);
		tick(4);
		chk(lines, 16'h0000);
		chk(16'(er), 16'h0000);
		redacc(8'h04);
		car <= 1'b1;
		tick(4);
		rq();
		wres();
		chk(lines, wexp(8'h53));
		chk(16'(gd), 16'h0001);
		chk(16'(par), 16'(^wexp(8'h53)));
		chk(green, wexp(8'h53));
		chk(ap, 16'h0053);
		chk(al, 16'h0054);
		tick(100);
		chk(lines, wexp(8'h53));
		lat <= 4'h6;
		rq();
		tick(3);
		chk(lines, 16'h0000);
		wres();
		car <= 1'b0;
		tick(19);
		chk(16'(gd), 16'h0001);
		tick(12);
		chk(16'(gd), 16'h0000);
		chk(lines, 16'h0000);
		chk(16'(par), 16'h0000);
		chk(green, wexp(8'h53));
		fail <= 1'b1;
		car <= 1'b1;
		tick(4);
		rq();
		wres();
		chk(lines, 16'h0001);
		chk(16'(er), 16'h0001);
		fail <= 1'b0;
		car <= 1'b0;
		// register port, then eeprom address limit
		rst(1'b0, 2'h0, 1'b0, 4'hF, 4'hD);
		rr(4'h3, 16'h0000);
		rw(4'h3, 16'h0001);
		rr(4'h3, 16'h0001);
		rw(4'hF, 16'hFFFF);
		rr(4'hF, 16'h0000);
		car <= 1'b1;
		rq();
		wres();
		chk(lines, 16'h0008);
		chk(16'(er), 16'h0001);
		car <= 1'b0;
		rst(1'b0, 2'h3, 1'b0, 4'h0, 4'h0);
		chk(16'(er), 16'h0001);
		chk(lines, 16'h0080);
		// automatic, wiring-saving, middle delay
		rst(1'b1, 2'h1, 1'b1, 4'h1, 4'h0);
		car <= 1'b1;
		wres();
		chk(lines, wexp(8'h10));
		chk(16'(stb), 16'h0001);
		chk(16'(gd), 16'h0000);
		chk({par, er, stb, lines[12:0]}, {^wexp(8'h10), 2'b01, 13'(wexp(8'h10))});
		tick(60);
		chk(16'(nf), 16'h0002);
		sup <= 1'b1;
		tick(6);
		chk(lines, 16'h0000);
		sup <= 1'b0;
		wres();
		chk(16'(nf), 16'h0004);
		car <= 1'b0;
		tick(39);
		chk(16'(stb), 16'h0001);
		tick(12);
		chk(16'(stb), 16'h0000);
		chk(lines, 16'h0000);
		ones <= 1'b1;
		car <= 1'b1;
		wres();
		chk(lines, 16'hFFFF);
		chk(16'(er), 16'h0001);
		chk(16'(stb), 16'h0001);
		redacc(8'h20);
		complete_run();
	end
endmodule : tag_word_read_output_control_bench

`default_nettype wire
